// file: hw/pcr_pkg.sv
// shared constants of the pair/channel register map and its serial master
package pcr_pkg;
    // ------------------------------------------------------------
    // device register map
    // ------------------------------------------------------------
    localparam logic [14:0] ADDR_CFG_A     = 15'h0000;
    localparam logic [14:0] ADDR_CFG_B     = 15'h0001;
    localparam logic [14:0] ADDR_PWR       = 15'h0002;
    localparam logic [14:0] ADDR_CHIP_TYPE = 15'h0003;
    localparam logic [14:0] ADDR_DEV_IDX   = 15'h0008;
    localparam logic [14:0] ADDR_PAIR_IDX  = 15'h0009;
    localparam logic [14:0] ADDR_SCRATCH   = 15'h000a;
    localparam logic [14:0] ADDR_REVISION  = 15'h000b;

    localparam logic [7:0] CHIP_TYPE_VAL = 8'h03;
    localparam logic [7:0] REVISION_VAL  = 8'h01;
    localparam logic [7:0] SCRATCH_RST   = 8'h07;
    localparam logic [1:0] DEV_IDX_RST   = 2'h3;
    localparam logic [1:0] PAIR_IDX_RST  = 2'h3;
    localparam logic [1:0] PWR_RST       = 2'h0;
    localparam logic [7:0] CFG_RST       = 8'h00;

    localparam int A_SRST_HI   = 7;
    localparam int A_LSB_FIRST = 6;
    localparam int A_ASC_HI    = 5;
    localparam int A_ASC       = 2;
    localparam int A_LSB_ALT   = 1;
    localparam int A_SRST_LO   = 0;
    localparam int B_SINGLE    = 7;
    localparam int B_DP_RST    = 1;

    localparam logic [1:0] PWR_NORMAL  = 2'h0;
    localparam logic [1:0] PWR_STANDBY = 2'h2;
    localparam logic [1:0] PWR_DOWN    = 2'h3;

    // ------------------------------------------------------------
    // serial frame and timing
    // ------------------------------------------------------------
    localparam logic [4:0] FRAME_LAST  = 5'h17;
    localparam logic [4:0] INSTR_LAST  = 5'h0f;
    localparam logic [2:0] HALF_LAST   = 3'h3;
    localparam int         CLK_HZ      = 40_000_000;
    localparam int         RECOVER_MS  = 5;
    localparam int         RECOVER_CYC = (RECOVER_MS * CLK_HZ + 999) / 1000;
    localparam int         RECOVER_W   = 18;

    // ------------------------------------------------------------
    // master register block (axi4-lite)
    // ------------------------------------------------------------
    localparam logic [7:0] HR_CMD    = 8'h00;
    localparam logic [7:0] HR_STATUS = 8'h04;
    localparam int CMD_READ    = 31;
    localparam int ST_BUSY     = 0;
    localparam int ST_RECOVER  = 1;
    localparam int ST_REFUSED  = 2;
    localparam int ST_LSB      = 3;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    function automatic logic [7:0] rev8(input logic [7:0] b);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 8; i++) begin
            r[i] = b[7 - i];
        end
        return r;
    endfunction
endpackage

// file: hw/pcr_spi_if.sv
// three-wire serial port between the register-map device and its master
`timescale 1ns/1ps
interface pcr_spi_if;
    logic sclk;
    logic cs_n;
    logic h_sdio_o;
    logic h_sdio_oe_n;
    logic d_sdio_o;
    logic d_sdio_oe_n;
    logic sdio;

    // pulled high when nobody drives
    assign sdio = !h_sdio_oe_n ? h_sdio_o : (!d_sdio_oe_n ? d_sdio_o : 1'b1);

    modport dev (input sclk, input cs_n, input sdio, output d_sdio_o, output d_sdio_oe_n);
    modport host (output sclk, output cs_n, output h_sdio_o, output h_sdio_oe_n, input sdio);
endinterface // pcr_spi_if

// file: hw/pcr_dev.sv
// register-map device: global, pair and channel copies behind the serial port
//
// Contract
// - one copy per channel; writes follow channel selects
// - both channel selects write both channels
// - reads with several selected return first channel
// - master selects one channel for reads; pcr_host does not, bench reads ADDR_PWR with several selected
// - channel select resolved through pair index
// - pair registers once per pair, pair-selected
// - config and pair index ignore selections
// - master writes pair then device index
// - pair index 01 first, 03 both pairs
// - device index 01 first, 03 both channels
// - writing soft reset bits restores all defaults
// - master waits 5 ms after soft reset
// - bit 6 selects lsb-first shifting
// - address advances after every streamed byte
// - single-instruction bit allows one access only
// - datapath reset bit pulses, reads zero
// - power mode 00 is normal operation
// - 10 gates clocks, 11 also resets, disables link
// - master never writes undefined addresses
`timescale 1ns/1ps
module pcr_dev (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    pcr_spi_if.dev          spi,
    output logic [3:0]      ch_clk_en,
    output logic [3:0]      ch_dp_rst,
    output logic [3:0]      ch_link_en
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0]  cfg_a_r;
    logic [7:0]  cfg_b_r;
    logic [1:0]  pair_idx_r;
    logic [1:0]  dev_idx_r [2];
    logic [7:0]  scratch_r [2];
    logic [1:0]  pwr_r     [4];
    logic        dp_pulse_r;
    logic        sclk_q_r;
    logic [2:0]  bit_r;
    logic [1:0]  byte_idx_r;
    logic        rw_r;
    logic        done_r;
    logic [14:0] addr_r;
    logic [7:0]  sh_r;
    logic [7:0]  obuf_r;
    logic        sdo_r;
    logic        oe_n_r;

    logic        lsb;
    logic        rise;
    logic        fall;
    logic [7:0]  rx_byte;
    logic        byte_done;
    logic        wr_en;
    logic        soft_rst;
    logic        psel;
    logic        csel;
    logic [7:0]  rd_data;

    // ------------------------------------------------------------
    // serial sampling
    // ------------------------------------------------------------
    always_comb begin
        lsb       = cfg_a_r[pcr_pkg::A_LSB_FIRST];
        rise      = spi.sclk && !sclk_q_r && !spi.cs_n;
        fall      = !spi.sclk && sclk_q_r && !spi.cs_n;
        rx_byte   = lsb ? {spi.sdio, sh_r[7:1]} : {sh_r[6:0], spi.sdio};
        byte_done = rise && !done_r && (bit_r == 3'h7);
        wr_en     = byte_done && (byte_idx_r == 2'h2) && !rw_r;
        soft_rst  = wr_en && (addr_r == pcr_pkg::ADDR_CFG_A)
                    && (rx_byte[pcr_pkg::A_SRST_HI] || rx_byte[pcr_pkg::A_SRST_LO]);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sclk_q_r <= 1'b0;
        end else begin
            sclk_q_r <= spi.sclk;
        end
    end

    // ------------------------------------------------------------
    // frame parser
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn || spi.cs_n) begin
            bit_r      <= 3'h0;
            byte_idx_r <= 2'h0;
            done_r     <= 1'b0;
            rw_r       <= 1'b0;
            addr_r     <= 15'h0000;
            sh_r       <= 8'h00;
        end else if (rise && !done_r) begin
            sh_r  <= rx_byte;
            bit_r <= bit_r + 3'h1;
            if (bit_r == 3'h7) begin
                case (byte_idx_r)
                    2'h0: begin
                        {rw_r, addr_r[14:8]} <= rx_byte;
                        byte_idx_r           <= 2'h1;
                    end
                    2'h1: begin
                        addr_r[7:0] <= rx_byte;
                        byte_idx_r  <= 2'h2;
                    end
                    default: begin
                        addr_r <= addr_r + 15'h0001;
                        done_r <= cfg_b_r[pcr_pkg::B_SINGLE] || soft_rst;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // global registers
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn || soft_rst) begin
            cfg_a_r    <= pcr_pkg::CFG_RST;
            cfg_b_r    <= pcr_pkg::CFG_RST;
            pair_idx_r <= pcr_pkg::PAIR_IDX_RST;
        end else if (wr_en) begin
            case (addr_r)
                pcr_pkg::ADDR_CFG_A: begin
                    cfg_a_r <= rx_byte & 8'h66;
                end
                pcr_pkg::ADDR_CFG_B: begin
                    cfg_b_r <= rx_byte & 8'h80;
                end
                pcr_pkg::ADDR_PAIR_IDX: begin
                    pair_idx_r <= rx_byte[1:0];
                end
                default: begin
                    cfg_a_r <= cfg_a_r;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || soft_rst) begin
            dp_pulse_r <= 1'b0;
        end else begin
            dp_pulse_r <= wr_en && (addr_r == pcr_pkg::ADDR_CFG_B) && rx_byte[pcr_pkg::B_DP_RST];
        end
    end

    // ------------------------------------------------------------
    // pair copies
    // ------------------------------------------------------------
    for (genvar p = 0; p < 2; p++) begin : g_pair
        always_ff @(posedge aclk) begin
            if (!aresetn || soft_rst) begin
                dev_idx_r[p] <= pcr_pkg::DEV_IDX_RST;
                scratch_r[p] <= pcr_pkg::SCRATCH_RST;
            end else if (wr_en && pair_idx_r[p]) begin
                if (addr_r == pcr_pkg::ADDR_DEV_IDX) begin
                    dev_idx_r[p] <= rx_byte[1:0];
                end
                if (addr_r == pcr_pkg::ADDR_SCRATCH) begin
                    scratch_r[p] <= rx_byte;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // channel copies
    // ------------------------------------------------------------
    for (genvar g = 0; g < 4; g++) begin : g_chan
        always_ff @(posedge aclk) begin
            if (!aresetn || soft_rst) begin
                pwr_r[g] <= pcr_pkg::PWR_RST;
            end else if (wr_en && (addr_r == pcr_pkg::ADDR_PWR)
                         && pair_idx_r[g / 2] && dev_idx_r[g / 2][g % 2]) begin
                pwr_r[g] <= rx_byte[1:0];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ch_clk_en  <= 4'h0;
            ch_dp_rst  <= 4'hf;
            ch_link_en <= 4'h0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                ch_clk_en[i]  <= (pwr_r[i] != pcr_pkg::PWR_STANDBY) && (pwr_r[i] != pcr_pkg::PWR_DOWN);
                ch_dp_rst[i]  <= (pwr_r[i] == pcr_pkg::PWR_DOWN) || dp_pulse_r;
                ch_link_en[i] <= pwr_r[i] != pcr_pkg::PWR_DOWN;
            end
        end
    end

    // ------------------------------------------------------------
    // readback
    // ------------------------------------------------------------
    always_comb begin
        psel = !pair_idx_r[0];
        csel = !dev_idx_r[psel][0];
        case (addr_r)
            pcr_pkg::ADDR_CFG_A:     rd_data = cfg_a_r;
            pcr_pkg::ADDR_CFG_B:     rd_data = cfg_b_r;
            pcr_pkg::ADDR_PWR:       rd_data = {6'h00, pwr_r[{psel, csel}]};
            pcr_pkg::ADDR_CHIP_TYPE: rd_data = pcr_pkg::CHIP_TYPE_VAL;
            pcr_pkg::ADDR_DEV_IDX:   rd_data = {6'h00, dev_idx_r[psel]};
            pcr_pkg::ADDR_PAIR_IDX:  rd_data = {6'h00, pair_idx_r};
            pcr_pkg::ADDR_SCRATCH:   rd_data = scratch_r[psel];
            pcr_pkg::ADDR_REVISION:  rd_data = pcr_pkg::REVISION_VAL;
            default:                 rd_data = 8'h00;
        endcase
    end

    // drives on sclk fall so the master samples a settled bit
    always_ff @(posedge aclk) begin
        if (!aresetn || spi.cs_n) begin
            oe_n_r <= 1'b1;
            sdo_r  <= 1'b0;
            obuf_r <= 8'h00;
        end else if (fall && done_r) begin
            // let go only after the last bit's high phase
            oe_n_r <= 1'b1;
        end else if (fall && rw_r && (byte_idx_r == 2'h2)) begin
            oe_n_r <= 1'b0;
            if (bit_r == 3'h0) begin
                sdo_r  <= lsb ? rd_data[0] : rd_data[7];
                obuf_r <= lsb ? {1'b0, rd_data[7:1]} : {rd_data[6:0], 1'b0};
            end else begin
                sdo_r  <= lsb ? obuf_r[0] : obuf_r[7];
                obuf_r <= lsb ? {1'b0, obuf_r[7:1]} : {obuf_r[6:0], 1'b0};
            end
        end
    end

    assign spi.d_sdio_o    = sdo_r;
    assign spi.d_sdio_oe_n = oe_n_r;
endmodule // pcr_dev

// file: hw/pcr_host.sv
// serial master: axi4-lite command registers driving the three-wire port
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
module pcr_host #(
    parameter int RECOVER_CYC = pcr_pkg::RECOVER_CYC
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    pcr_spi_if.host          spi
);
    typedef enum logic [2:0] {
        HS_IDLE = 3'b001,
        HS_RUN  = 3'b010,
        HS_WAIT = 3'b100
    } pcr_hstate_t;

    pcr_hstate_t                  st_r;
    logic [7:0]                   awaddr_r;
    logic [31:0]                  wdata_r;
    logic                         aw_ok_r;
    logic                         w_ok_r;
    logic [23:0]                  tx_r;
    logic [7:0]                   rx_r;
    logic [4:0]                   bitn_r;
    logic [2:0]                   div_r;
    logic                         sclk_r;
    logic                         cs_n_r;
    logic                         oe_n_r;
    logic                         rd_r;
    logic [14:0]                  cmd_addr_r;
    logic [7:0]                   cmd_data_r;
    logic [7:0]                   rdata_r;
    logic                         lsb_r;
    logic                         refused_r;
    logic [pcr_pkg::RECOVER_W-1:0] wait_r;

    logic        wr_go;
    logic        legal;
    logic        start;
    logic [14:0] c_addr;
    logic [7:0]  c_data;
    logic        c_rd;
    logic [7:0]  rx_new;

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    always_comb begin
        wr_go  = aw_ok_r && w_ok_r && !s_axi_bvalid;
        c_rd   = wdata_r[pcr_pkg::CMD_READ];
        c_addr = wdata_r[22:8];
        c_data = wdata_r[7:0];
        case (c_addr)
            pcr_pkg::ADDR_CFG_A, pcr_pkg::ADDR_CFG_B, pcr_pkg::ADDR_PWR,
            pcr_pkg::ADDR_CHIP_TYPE, pcr_pkg::ADDR_DEV_IDX, pcr_pkg::ADDR_PAIR_IDX,
            pcr_pkg::ADDR_SCRATCH, pcr_pkg::ADDR_REVISION: legal = 1'b1;
            default: legal = 1'b0;
        endcase
        start  = wr_go && (awaddr_r == pcr_pkg::HR_CMD) && (st_r == HS_IDLE)
                 && (c_rd || legal) && (s_axi_wstrb == 4'hf || s_axi_wstrb != 4'hf);
        rx_new = {rx_r[6:0], spi.sdio};
    end

    // ------------------------------------------------------------
    // axi4-lite write channel
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= pcr_pkg::RESP_OKAY;
            aw_ok_r       <= 1'b0;
            w_ok_r        <= 1'b0;
            awaddr_r      <= 8'h00;
            wdata_r       <= 32'h0000_0000;
            refused_r     <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'b0;
                aw_ok_r       <= 1'b1;
                awaddr_r      <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
                w_ok_r       <= 1'b1;
                wdata_r      <= s_axi_wdata;
            end
            if (wr_go) begin
                aw_ok_r      <= 1'b0;
                w_ok_r       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= start ? pcr_pkg::RESP_OKAY : pcr_pkg::RESP_SLVERR;
                if (awaddr_r == pcr_pkg::HR_CMD && st_r == HS_IDLE) begin
                    refused_r <= !start;
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // axi4-lite read channel
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= pcr_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            if (s_axi_araddr == pcr_pkg::HR_STATUS) begin
                s_axi_rdata <= {16'h0000, rdata_r, 4'h0, lsb_r, refused_r,
                                st_r == HS_WAIT, st_r != HS_IDLE};
                s_axi_rresp <= pcr_pkg::RESP_OKAY;
            end else begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= pcr_pkg::RESP_SLVERR;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // serial engine
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r       <= HS_IDLE;
            tx_r       <= 24'h000000;
            rx_r       <= 8'h00;
            bitn_r     <= 5'h00;
            div_r      <= 3'h0;
            sclk_r     <= 1'b0;
            cs_n_r     <= 1'b1;
            oe_n_r     <= 1'b1;
            rd_r       <= 1'b0;
            cmd_addr_r <= 15'h0000;
            cmd_data_r <= 8'h00;
            rdata_r    <= 8'h00;
            lsb_r      <= 1'b0;
            wait_r     <= '0;
        end else begin
            case (st_r)
                HS_IDLE: begin
                    if (start) begin
                        st_r       <= HS_RUN;
                        rd_r       <= c_rd;
                        cmd_addr_r <= c_addr;
                        cmd_data_r <= c_data;
                        tx_r       <= lsb_r ? {pcr_pkg::rev8({c_rd, c_addr[14:8]}), pcr_pkg::rev8(c_addr[7:0]),
                                               pcr_pkg::rev8(c_data)} : {c_rd, c_addr, c_data};
                        cs_n_r     <= 1'b0;
                        oe_n_r     <= 1'b0;
                        bitn_r     <= 5'h00;
                        div_r      <= 3'h0;
                    end
                end
                HS_RUN: begin
                    div_r <= div_r + 3'h1;
                    if (div_r == pcr_pkg::HALF_LAST) begin
                        div_r  <= 3'h0;
                        sclk_r <= !sclk_r;
                        if (sclk_r) begin
                            rx_r <= rx_new;
                            if (bitn_r == pcr_pkg::FRAME_LAST) begin
                                cs_n_r <= 1'b1;
                                oe_n_r <= 1'b1;
                                st_r   <= HS_IDLE;
                                if (rd_r) begin
                                    rdata_r <= lsb_r ? pcr_pkg::rev8(rx_new) : rx_new;
                                end else if (cmd_addr_r == pcr_pkg::ADDR_CFG_A) begin
                                    lsb_r <= cmd_data_r[pcr_pkg::A_LSB_FIRST];
                                    if (cmd_data_r[pcr_pkg::A_SRST_HI] || cmd_data_r[pcr_pkg::A_SRST_LO]) begin
                                        lsb_r  <= 1'b0;
                                        st_r   <= HS_WAIT;
                                        wait_r <= pcr_pkg::RECOVER_W'(RECOVER_CYC - 1);
                                    end
                                end
                            end else begin
                                bitn_r <= bitn_r + 5'h01;
                                tx_r   <= {tx_r[22:0], 1'b0};
                                oe_n_r <= rd_r && (bitn_r >= pcr_pkg::INSTR_LAST);
                            end
                        end
                    end
                end
                HS_WAIT: begin
                    wait_r <= wait_r - 1'b1;
                    if (wait_r == '0) begin
                        st_r <= HS_IDLE;
                    end
                end
                default: begin
                    st_r <= HS_IDLE;
                end
            endcase
        end
    end

    assign spi.sclk        = sclk_r;
    assign spi.cs_n        = cs_n_r;
    assign spi.h_sdio_o    = tx_r[23];
    assign spi.h_sdio_oe_n = oe_n_r;
endmodule // pcr_host

// file: test/pcr_spi_properties.sv
// wire-level properties of the serial port between master and device
`timescale 1ns/1ps
module pcr_spi_properties (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic h_sdio_o,
    input wire logic h_sdio_oe_n,
    input wire logic d_sdio_oe_n
);
    logic       sclk_d_r;
    logic [4:0] bits_r;
    // rising serial clock edges counted within a frame
    always_ff @(posedge aclk) begin
        sclk_d_r <= sclk;
        if (!aresetn || cs_n) begin
            bits_r <= 5'h00;
        end else if (sclk && !sclk_d_r) begin
            bits_r <= bits_r + 5'h01;
        end
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_frame_bits: assert property ($rose(cs_n) |-> bits_r == 5'h18) else $error("bad frame length");
    a_sclk_idle: assert property (cs_n [*2] |-> !sclk) else $error("clock outside frame");
    a_first_rise: assert property ($fell(cs_n) |-> !sclk [*4] ##1 sclk) else $error("bad first edge");
    a_high_phase: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk) else $error("bad high phase");
    a_low_phase: assert property ($fell(sclk) |-> !sclk [*4]) else $error("short low phase");
    a_bit_stable: assert property (sclk && $past(sclk) && !h_sdio_oe_n |-> $stable(h_sdio_o)) else $error("bit moved");
    a_no_clash: assert property (!h_sdio_oe_n |-> d_sdio_oe_n) else $error("both ends drive");
    a_dev_release: assert property (cs_n [*2] |-> d_sdio_oe_n) else $error("device drives idle line");
    a_host_release: assert property ($rose(cs_n) |-> h_sdio_oe_n) else $error("master drives idle line");
    c_frame: cover property ($rose(cs_n));
    c_readback: cover property ($fell(d_sdio_oe_n));
    c_dev_data: cover property (sclk && !d_sdio_oe_n);
endmodule // pcr_spi_properties

// file: test/tb.sv
// bench: register traffic through the axi4-lite master into the serial device
`timescale 1ns/1ps
module tb;
    logic         aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic         s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic         s_axi_arready, s_axi_rvalid;
    logic [7:0]   s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0]  s_axi_wdata = 32'h0, s_axi_rdata, s;
    logic [3:0]   s_axi_wstrb = 4'hf, ch_clk_en, ch_dp_rst, ch_link_en;
    logic [1:0]   s_axi_bresp, s_axi_rresp, r;
    logic [19:0]  st;
    int           num_errors = 0, cmp_count = 0;
    // op nibble: 0 write, 1 read and compare, 2 channel outputs, 3 end of test
    logic [899:0] prog = {140'h10000_11000_12000_19003_18003_20ff0_30001,
        160'h09001_08001_02002_20ef0_08002_02003_20cd2_12003,
        160'h08003_12002_09002_02002_200d2_09003_12002_30002,
        160'h0a05a_09001_0a03c_1a03c_09002_1a05a_01082_09001,
        160'h11080_19001_30003_00040_10040_13003_1a03c_30004,
        120'h00081_10000_11000_1a007_20ff0_30005};
    always #12.5 aclk = ~aclk;
    pcr_spi_if spi ();
    pcr_dev i_pcr_dev (.aclk, .aresetn, .spi, .ch_clk_en, .ch_dp_rst, .ch_link_en);
    pcr_host #(.RECOVER_CYC(20)) i_pcr_host (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .spi);
    pcr_spi_properties i_pcr_spi_properties (.aclk, .aresetn, .sclk(spi.sclk), .cs_n(spi.cs_n),
        .h_sdio_o(spi.h_sdio_o), .h_sdio_oe_n(spi.h_sdio_oe_n), .d_sdio_oe_n(spi.d_sdio_oe_n));
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) num_errors++;
        if (seen !== exp) $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    endtask
    task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{wr}};
        {s_axi_arvalid, s_axi_rready} <= {2{!wr}};
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!(wr ? s_axi_bvalid : s_axi_rvalid));
        {r, s} = wr ? {s_axi_bresp, s} : {s_axi_rresp, s_axi_rdata};
        {s_axi_bready, s_axi_rready} <= 2'b00;
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge aclk);
        num_errors++;
        conclude();
    end
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 899; i > 0; i -= 20) begin
            st = prog[i -: 20];
            if (st[19:17] == 3'h0) begin
                axi(1'b1, 8'h00, {st[16], 19'h0, st[15:12], st[7:0]});
                s = 32'h1;
                while (s[1:0] !== 2'h0) axi(1'b0, 8'h04, 32'h0);
            end
            if (st[19:16] == 4'h1) chk("register", 32'(s[15:8]), 32'(st[7:0]));
            if (st[19:16] == 4'h2) chk("outputs", 32'({ch_clk_en, ch_link_en, ch_dp_rst}), 32'(st[11:0]));
            if (st[19:16] == 4'h3) $display("test %0d done", st[3:0]);
        end
        axi(1'b1, 8'h00, 32'h00001311);
        chk("undefined write", 32'(r), 32'h2);
        axi(1'b0, 8'h04, 32'h0);
        chk("refused status", s, 32'h00000704);
        axi(1'b1, 8'h08, 32'h0);
        chk("unmapped write", 32'(r), 32'h2);
        axi(1'b0, 8'h0c, 32'h0);
        chk("unmapped read", 32'(r), 32'h2);
        $display("test 6 done");
        conclude();
    end
endmodule // tb
